// *** rtl/ccd_pkg.sv ***
package ccd_pkg;
    // =============================================
    // Register indices (byte address = index * 4)
    localparam int unsigned      ADDR_W       = 14;
    localparam logic [11:0]      IDX_S1_CNT   = 12'h19E;
    localparam logic [11:0]      IDX_PHASE    = 12'h19F;
    localparam logic [11:0]      IDX_S2_CNT   = 12'h1A0;
    localparam logic [11:0]      IDX_CTRL     = 12'h1A1;
    localparam logic [11:0]      IDX_DCC      = 12'h1A2;
    localparam logic [11:0]      IDX_STATUS   = 12'h1A3;
    // =============================================
    // Field layout
    localparam int unsigned      NIB_W        = 4;
    localparam int unsigned      CNT_LOW_LSB  = 4;
    localparam int unsigned      CNT_HIGH_LSB = 0;
    localparam int unsigned      PH_S2_LSB    = 4;
    localparam int unsigned      PH_S1_LSB    = 0;
    localparam int unsigned      CTL_BYP2     = 5;
    localparam int unsigned      CTL_BYP1     = 4;
    localparam int unsigned      CTL_NOSYNC   = 3;
    localparam int unsigned      CTL_FORCE    = 2;
    localparam int unsigned      CTL_START2   = 1;
    localparam int unsigned      CTL_START1   = 0;
    localparam int unsigned      DCC_OFF_BIT  = 0;
    localparam logic [7:0]       CTRL_MASK    = 8'h3F;
    localparam logic [7:0]       DCC_MASK     = 8'h01;
    // =============================================
    // Reset values
    localparam logic [7:0]       RST_CNT      = 8'h00;
    localparam logic [7:0]       RST_PHASE    = 8'h00;
    localparam logic [7:0]       RST_CTRL     = 8'h00;
    localparam logic [7:0]       RST_DCC      = 8'h00;
    // =============================================
    // Bus answers and timing
    localparam logic [1:0]       RESP_OKAY    = 2'h0;
    localparam logic [1:0]       RESP_SLVERR  = 2'h2;
    localparam int unsigned      DIST_DIV_DEF = 1;
    localparam int unsigned      PERIOD_W     = 16;

    typedef enum logic [1:0] {ST_HOLD, ST_PHASE, ST_HIGH, ST_LOW} ccd_stage_state_t;
endpackage

// *** rtl/ccd_stage_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// =============================================
// Settings and outputs of one divider stage
interface ccd_stage_if;
    logic [3:0] high_cnt;
    logic [3:0] low_cnt;
    logic [3:0] phase;
    logic       bypass;
    logic       start_hi;
    logic       hold;
    logic       tick_in;
    logic       lvl;
    logic       tick_out;

    modport stage (input high_cnt, low_cnt, phase, bypass, start_hi, hold, tick_in,
                   output lvl, tick_out);
    modport ctrl  (output high_cnt, low_cnt, phase, bypass, start_hi, hold, tick_in,
                   input lvl, tick_out);
endinterface
`default_nettype wire

// *** rtl/ccd_div_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccd_div_stage
(
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    ccd_stage_if.stage sif
);
    ccd_pkg::ccd_stage_state_t state_q;
    logic [3:0]                cnt_q;
    logic                      lvl_q;
    logic                      tick_q;

    // =============================================
    // Counter and phase machine, advances on input ticks
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ccd_pkg::ST_HOLD;
            cnt_q   <= 4'h0;
        end
        else if (sif.hold || sif.bypass)
        begin
            // Counting logic parked while bypassed (power down)
            state_q <= ccd_pkg::ST_HOLD;
            cnt_q   <= 4'h0;
        end
        else if (sif.tick_in)
        begin
            case (state_q)
                ccd_pkg::ST_HOLD:
                begin
                    if (sif.phase != 4'h0)
                    begin
                        state_q <= ccd_pkg::ST_PHASE;
                        cnt_q   <= sif.phase - 4'h1;
                    end
                    else
                    begin
                        state_q <= sif.start_hi ? ccd_pkg::ST_HIGH : ccd_pkg::ST_LOW;
                        cnt_q   <= sif.start_hi ? sif.high_cnt : sif.low_cnt;
                    end
                end
                ccd_pkg::ST_PHASE:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q <= sif.start_hi ? ccd_pkg::ST_HIGH : ccd_pkg::ST_LOW;
                        cnt_q   <= sif.start_hi ? sif.high_cnt : sif.low_cnt;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                ccd_pkg::ST_HIGH:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q <= ccd_pkg::ST_LOW;
                        cnt_q   <= sif.low_cnt;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
                default:
                begin
                    if (cnt_q == 4'h0)
                    begin
                        state_q <= ccd_pkg::ST_HIGH;
                        cnt_q   <= sif.high_cnt;
                    end
                    else
                        cnt_q <= cnt_q - 4'h1;
                end
            endcase
        end
    end

    // =============================================
    // Output level; start level shown while held or offset
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lvl_q  <= 1'b0;
            tick_q <= 1'b0;
        end
        else if (sif.bypass)
        begin
            lvl_q  <= sif.tick_in;
            tick_q <= sif.tick_in;
        end
        else
        begin
            lvl_q  <= (state_q == ccd_pkg::ST_HIGH) ||
                      ((state_q == ccd_pkg::ST_HOLD || state_q == ccd_pkg::ST_PHASE)
                       && sif.start_hi);
            tick_q <= sif.tick_in && !sif.hold && (state_q == ccd_pkg::ST_LOW)
                      && (cnt_q == 4'h0);
        end
    end

    assign sif.lvl      = lvl_q;
    assign sif.tick_out = tick_q;
endmodule
`default_nettype wire

// *** rtl/ccd_duty_fix.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccd_duty_fix
#(
    parameter int unsigned PERIOD_W = ccd_pkg::PERIOD_W
)
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_en,
    input  wire logic i_lvl,
    output logic      o_lvl
);
    logic                rise;
    logic                prev_q;
    logic [PERIOD_W-1:0] per_cnt_q;
    logic [PERIOD_W-1:0] half_q;
    logic [PERIOD_W-1:0] pos_q;
    logic                out_q;

    assign rise = i_lvl && !prev_q;

    // =============================================
    // Measure last period; rebuild a half-period high
    // Needs one full period to settle after a ratio change
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            prev_q    <= 1'b0;
            per_cnt_q <= '0;
            half_q    <= '0;
            pos_q     <= '0;
            out_q     <= 1'b0;
        end
        else
        begin
            prev_q <= i_lvl;
            if (rise)
            begin
                per_cnt_q <= {{(PERIOD_W-1){1'b0}}, 1'b1};
                half_q    <= (per_cnt_q >> 1) == '0 ? {{(PERIOD_W-1){1'b0}}, 1'b1}
                                                    : per_cnt_q >> 1;
                pos_q     <= '0;
            end
            else
            begin
                per_cnt_q <= per_cnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
                pos_q     <= pos_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
            end
            out_q <= i_en ? (rise || (pos_q + 1'b1 < half_q && !rise && prev_q | out_q))
                          : i_lvl;
        end
    end

    assign o_lvl = out_q;
endmodule
`default_nettype wire

// *** rtl/ccd_channel_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccd_channel_top
#(
    parameter int unsigned DIST_DIV = ccd_pkg::DIST_DIV_DEF
)
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_SYNC_N,
    input  wire logic [13:0] I_S_AXI_AWADDR,
    input  wire logic        I_S_AXI_AWVALID,
    output logic             O_S_AXI_AWREADY,
    input  wire logic [31:0] I_S_AXI_WDATA,
    input  wire logic [3:0]  I_S_AXI_WSTRB,
    input  wire logic        I_S_AXI_WVALID,
    output logic             O_S_AXI_WREADY,
    output logic [1:0]       O_S_AXI_BRESP,
    output logic             O_S_AXI_BVALID,
    input  wire logic        I_S_AXI_BREADY,
    input  wire logic [13:0] I_S_AXI_ARADDR,
    input  wire logic        I_S_AXI_ARVALID,
    output logic             O_S_AXI_ARREADY,
    output logic [31:0]      O_S_AXI_RDATA,
    output logic [1:0]       O_S_AXI_RRESP,
    output logic             O_S_AXI_RVALID,
    input  wire logic        I_S_AXI_RREADY,
    output logic             O_CLK_OUT,
    output logic             O_CLK_TICK,
    output logic             O_STAGE1_CLK
);
    // =============================================
    // Declarations
    localparam int unsigned DIV_W = (DIST_DIV > 1) ? $clog2(DIST_DIV) : 1;

    logic [7:0]       s1_cnt_q;
    logic [7:0]       phase_q;
    logic [7:0]       s2_cnt_q;
    logic [7:0]       ctrl_q;
    logic [7:0]       dcc_q;

    logic             sync_meta_q;
    logic             sync_n_q;
    logic             sync_hold;

    logic [DIV_W-1:0] dist_cnt_q;
    logic             dist_tick_q;

    logic [11:0]      aw_idx_q;
    logic             aw_full_q;
    logic [31:0]      w_data_q;
    logic [3:0]       w_strb_q;
    logic             w_full_q;
    logic             wr_go;

    logic             raw_lvl;
    logic             fixed_lvl;
    logic             force_now;

    ccd_stage_if s1_if ();
    ccd_stage_if s2_if ();

    // =============================================
    // Index decode, shared by read and write paths
    function automatic logic idx_mapped(input logic [11:0] idx);
        idx_mapped = (idx == ccd_pkg::IDX_S1_CNT) || (idx == ccd_pkg::IDX_PHASE)
                  || (idx == ccd_pkg::IDX_S2_CNT) || (idx == ccd_pkg::IDX_CTRL)
                  || (idx == ccd_pkg::IDX_DCC)    || (idx == ccd_pkg::IDX_STATUS);
    endfunction

    function automatic logic [11:0] byte_to_idx(input logic [13:0] addr);
        byte_to_idx = addr[13:2];
    endfunction

    // =============================================
    // Chip sync pin: two flops before any use
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            sync_meta_q <= 1'b1;
            sync_n_q    <= 1'b1;
        end
        else
        begin
            sync_meta_q <= I_SYNC_N;
            sync_n_q    <= sync_meta_q;
        end
    end

    // Sync holds the dividers unless ignored
    assign sync_hold = !sync_n_q && !ctrl_q[ccd_pkg::CTL_NOSYNC];

    // =============================================
    // Distribution clock as an enable pulse
    // Single clock domain, so the tree rate is a divided tick
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            dist_cnt_q  <= '0;
            dist_tick_q <= 1'b0;
        end
        else if (dist_cnt_q == DIV_W'(DIST_DIV - 1))
        begin
            dist_cnt_q  <= '0;
            dist_tick_q <= 1'b1;
        end
        else
        begin
            dist_cnt_q  <= dist_cnt_q + 1'b1;
            dist_tick_q <= 1'b0;
        end
    end

    // =============================================
    // Stage settings from the register file
    assign s1_if.high_cnt = s1_cnt_q[ccd_pkg::CNT_HIGH_LSB +: ccd_pkg::NIB_W];
    assign s1_if.low_cnt  = s1_cnt_q[ccd_pkg::CNT_LOW_LSB +: ccd_pkg::NIB_W];
    assign s1_if.phase    = phase_q[ccd_pkg::PH_S1_LSB +: ccd_pkg::NIB_W];
    assign s1_if.bypass   = ctrl_q[ccd_pkg::CTL_BYP1];
    assign s1_if.start_hi = ctrl_q[ccd_pkg::CTL_START1];
    assign s1_if.hold     = sync_hold;
    assign s1_if.tick_in  = dist_tick_q;

    // Second stage counts first-stage periods
    assign s2_if.high_cnt = s2_cnt_q[ccd_pkg::CNT_HIGH_LSB +: ccd_pkg::NIB_W];
    assign s2_if.low_cnt  = s2_cnt_q[ccd_pkg::CNT_LOW_LSB +: ccd_pkg::NIB_W];
    assign s2_if.phase    = phase_q[ccd_pkg::PH_S2_LSB +: ccd_pkg::NIB_W];
    assign s2_if.bypass   = ctrl_q[ccd_pkg::CTL_BYP2];
    assign s2_if.start_hi = ctrl_q[ccd_pkg::CTL_START2];
    assign s2_if.hold     = sync_hold;
    assign s2_if.tick_in  = s1_if.tick_out;

    // =============================================
    // The two cascaded stages
    ccd_div_stage u_stage1
    (
        .i_clk (I_SYS_CLK),
        .i_rst (I_RST),
        .sif   (s1_if.stage)
    );

    ccd_div_stage u_stage2
    (
        .i_clk (I_SYS_CLK),
        .i_rst (I_RST),
        .sif   (s2_if.stage)
    );

    assign raw_lvl = s2_if.lvl;

    // =============================================
    // Duty-cycle correction on the channel output
    ccd_duty_fix #(
        .PERIOD_W (ccd_pkg::PERIOD_W)
    ) u_duty
    (
        .i_clk (I_SYS_CLK),
        .i_rst (I_RST),
        .i_en  (!dcc_q[ccd_pkg::DCC_OFF_BIT]),
        .i_lvl (raw_lvl),
        .o_lvl (fixed_lvl)
    );

    // Static level only while sync is ignored and sync is asserted
    assign force_now = ctrl_q[ccd_pkg::CTL_NOSYNC] && !sync_n_q;

    // =============================================
    // Channel outputs, all registered
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_CLK_OUT    <= 1'b0;
            O_CLK_TICK   <= 1'b0;
            O_STAGE1_CLK <= 1'b0;
        end
        else
        begin
            O_CLK_OUT    <= force_now ? ctrl_q[ccd_pkg::CTL_FORCE] : fixed_lvl;
            O_CLK_TICK   <= s2_if.tick_out && !force_now;
            O_STAGE1_CLK <= s1_if.lvl;
        end
    end

    // =============================================
    // Write address channel, held until the write completes
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            aw_idx_q        <= 12'h000;
            aw_full_q       <= 1'b0;
            O_S_AXI_AWREADY <= 1'b0;
        end
        else
        begin
            O_S_AXI_AWREADY <= !aw_full_q && !O_S_AXI_AWREADY && I_S_AXI_AWVALID;
            if (O_S_AXI_AWREADY && I_S_AXI_AWVALID)
            begin
                aw_idx_q  <= byte_to_idx(I_S_AXI_AWADDR);
                aw_full_q <= 1'b1;
            end
            else if (wr_go)
            begin
                // Freed only by the commit
                aw_full_q <= 1'b0;
            end
        end
    end

    // =============================================
    // Write data channel, taken independently of the address
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            w_data_q       <= 32'h0000_0000;
            w_strb_q       <= 4'h0;
            w_full_q       <= 1'b0;
            O_S_AXI_WREADY <= 1'b0;
        end
        else
        begin
            O_S_AXI_WREADY <= !w_full_q && !O_S_AXI_WREADY && I_S_AXI_WVALID;
            if (O_S_AXI_WREADY && I_S_AXI_WVALID)
            begin
                w_data_q <= I_S_AXI_WDATA;
                w_strb_q <= I_S_AXI_WSTRB;
                w_full_q <= 1'b1;
            end
            else if (wr_go)
            begin
                // Freed even when lane 0 is off
                w_full_q <= 1'b0;
            end
        end
    end

    // Commit once both halves are in and no response waits
    assign wr_go = aw_full_q && w_full_q && !O_S_AXI_BVALID;

    // =============================================
    // Write response
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_S_AXI_BVALID <= 1'b0;
            O_S_AXI_BRESP  <= ccd_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            O_S_AXI_BVALID <= 1'b1;
            O_S_AXI_BRESP  <= idx_mapped(aw_idx_q) ? ccd_pkg::RESP_OKAY
                                                   : ccd_pkg::RESP_SLVERR;
        end
        else if (I_S_AXI_BREADY)
        begin
            // Stands until taken
            O_S_AXI_BVALID <= 1'b0;
        end
    end

    // =============================================
    // Register file; only byte lane 0 carries data
    // Settings change on the fly, so a divider may glitch once
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            s1_cnt_q <= ccd_pkg::RST_CNT;
            phase_q  <= ccd_pkg::RST_PHASE;
            s2_cnt_q <= ccd_pkg::RST_CNT;
            ctrl_q   <= ccd_pkg::RST_CTRL;
            dcc_q    <= ccd_pkg::RST_DCC;
        end
        else if (wr_go && w_strb_q[0])
        begin
            case (aw_idx_q)
                ccd_pkg::IDX_S1_CNT: s1_cnt_q <= w_data_q[7:0];
                ccd_pkg::IDX_PHASE:  phase_q  <= w_data_q[7:0];
                ccd_pkg::IDX_S2_CNT: s2_cnt_q <= w_data_q[7:0];
                ccd_pkg::IDX_CTRL:   ctrl_q   <= w_data_q[7:0] & ccd_pkg::CTRL_MASK;
                ccd_pkg::IDX_DCC:    dcc_q    <= w_data_q[7:0] & ccd_pkg::DCC_MASK;
                default:             ;
            endcase
        end
    end

    // =============================================
    // Read channel: one cycle to accept, data registered
    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_S_AXI_ARREADY <= 1'b0;
            O_S_AXI_RVALID  <= 1'b0;
            O_S_AXI_RDATA   <= 32'h0000_0000;
            O_S_AXI_RRESP   <= ccd_pkg::RESP_OKAY;
        end
        else
        begin
            O_S_AXI_ARREADY <= !O_S_AXI_ARREADY && !O_S_AXI_RVALID && I_S_AXI_ARVALID;
            if (O_S_AXI_ARREADY && I_S_AXI_ARVALID)
            begin
                O_S_AXI_RVALID <= 1'b1;
                O_S_AXI_RRESP  <= idx_mapped(byte_to_idx(I_S_AXI_ARADDR))
                                  ? ccd_pkg::RESP_OKAY : ccd_pkg::RESP_SLVERR;
                case (byte_to_idx(I_S_AXI_ARADDR))
                    ccd_pkg::IDX_S1_CNT: O_S_AXI_RDATA <= {24'h000000, s1_cnt_q};
                    ccd_pkg::IDX_PHASE:  O_S_AXI_RDATA <= {24'h000000, phase_q};
                    ccd_pkg::IDX_S2_CNT: O_S_AXI_RDATA <= {24'h000000, s2_cnt_q};
                    ccd_pkg::IDX_CTRL:   O_S_AXI_RDATA <= {24'h000000, ctrl_q};
                    ccd_pkg::IDX_DCC:    O_S_AXI_RDATA <= {24'h000000, dcc_q};
                    ccd_pkg::IDX_STATUS: O_S_AXI_RDATA <= {28'h0000000, sync_hold,
                                                           s2_if.lvl, s1_if.lvl,
                                                           O_CLK_OUT};
                    default:             O_S_AXI_RDATA <= 32'h0000_0000;
                endcase
            end
            else if (I_S_AXI_RREADY)
            begin
                // Data stands until taken
                O_S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/ccd_channel_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccd_channel_props
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_S_AXI_ARVALID,
    input  wire logic        O_S_AXI_ARREADY,
    input  wire logic        O_S_AXI_AWREADY,
    input  wire logic        O_S_AXI_WREADY,
    input  wire logic        O_S_AXI_BVALID,
    input  wire logic        I_S_AXI_BREADY,
    input  wire logic [31:0] O_S_AXI_RDATA,
    input  wire logic [1:0]  O_S_AXI_RRESP,
    input  wire logic        O_S_AXI_RVALID,
    input  wire logic        I_S_AXI_RREADY,
    input  wire logic        O_CLK_OUT,
    input  wire logic        O_STAGE1_CLK
);
    // =============================================
    // Register bus handshakes
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    // Read goes through address then data, upper byte lanes always zero
    sequence ar_taken;
        I_S_AXI_ARVALID && O_S_AXI_ARREADY;
    endsequence
    sequence rd_answer;
        O_S_AXI_RVALID ##0 (O_S_AXI_RDATA[31:8] == 24'h000000);
    endsequence
    rd_follow_a: assert property (ar_taken |=> rd_answer)
        else $error("read answer missing after address");
    slverr_zero_a: assert property (O_S_AXI_RVALID && O_S_AXI_RRESP == ccd_pkg::RESP_SLVERR
        |-> O_S_AXI_RDATA == 32'h00000000) else $error("refused read carries data");
    aw_pulse_a: assert property (O_S_AXI_AWREADY |=> !O_S_AXI_AWREADY)
        else $error("write address ready longer than one cycle");
    wr_resp_a: assert property (O_S_AXI_AWREADY && O_S_AXI_WREADY |-> ##2 O_S_AXI_BVALID)
        else $error("write response late");
    b_drop_a: assert property (O_S_AXI_BVALID && I_S_AXI_BREADY |=> !O_S_AXI_BVALID)
        else $error("write response not released");
    r_drop_a: assert property (O_S_AXI_RVALID && I_S_AXI_RREADY |=> !O_S_AXI_RVALID)
        else $error("read response not released");
    ar_block_a: assert property (O_S_AXI_RVALID |-> !O_S_AXI_ARREADY)
        else $error("read address taken while answer pending");
    rst_quiet_a: assert property ($fell(I_RST) |-> !O_S_AXI_BVALID && !O_S_AXI_RVALID
        && !O_CLK_OUT && !O_STAGE1_CLK) else $error("outputs active right after reset");
endmodule
bind ccd_channel_top ccd_channel_props u_props (.I_SYS_CLK, .I_RST, .I_S_AXI_ARVALID,
    .O_S_AXI_ARREADY, .O_S_AXI_AWREADY, .O_S_AXI_WREADY, .O_S_AXI_BVALID, .I_S_AXI_BREADY,
    .O_S_AXI_RDATA, .O_S_AXI_RRESP, .O_S_AXI_RVALID, .I_S_AXI_RREADY, .O_CLK_OUT, .O_STAGE1_CLK);
`default_nettype wire

// *** verification/ccd_consumer.sv ***
`timescale 1ns/1ps
`default_nettype none
// =============================================
// Downstream clock consumer: times each level run
module ccd_consumer
(
    input  wire logic  i_clk,
    input  wire logic  i_lvl,
    output logic [7:0] o_hi,
    output logic [7:0] o_lo
);
    logic       prev_q;
    logic [7:0] run_q;
    // Latch run length at each edge; unknown until the first full run
    always_ff @(posedge i_clk)
    begin
        prev_q <= i_lvl;
        run_q  <= (i_lvl != prev_q) ? 8'h01 : run_q + 8'h01;
        if (i_lvl != prev_q && prev_q)
            o_hi <= run_q;
        if (i_lvl != prev_q && !prev_q)
            o_lo <= run_q;
    end
endmodule
`default_nettype wire

// *** verification/cascaded_channel_divider_pair_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cascaded_channel_divider_pair_tb;
    localparam logic [1:0] OK  = ccd_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = ccd_pkg::RESP_SLVERR;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sync_n = 1'b1;
    logic [13:0] awaddr = 14'h0000;
    logic [13:0] araddr = 14'h0000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        bready = 1'b0;
    logic        arv = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, clk_out, s1_clk, tick;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  out_hi, out_lo, s1_hi, s1_lo, tk_hi, tk_lo;
    int          failures = 0;
    int          checks_done = 0;
    // Mode, then high/low runs of channel output and first stage, DIST_DIV 2
    logic [39:0] tbl [4] = '{40'h00_12_18_02_04, 40'h20_01_05_02_04,
                             40'h04_12_18_02_04, 40'h10_06_08_01_01};
    // =============================================
    // Clock, design and consumers
    always #25 clk = ~clk;
    ccd_channel_top #(.DIST_DIV(2)) dut (.I_SYS_CLK(clk), .I_RST(rst), .I_SYNC_N(sync_n),
        .I_S_AXI_AWADDR(awaddr), .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awready),
        .I_S_AXI_WDATA(wdata), .I_S_AXI_WSTRB(wstrb), .I_S_AXI_WVALID(wv),
        .O_S_AXI_WREADY(wready), .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bvalid),
        .I_S_AXI_BREADY(bready), .I_S_AXI_ARADDR(araddr), .I_S_AXI_ARVALID(arv),
        .O_S_AXI_ARREADY(arready), .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp),
        .O_S_AXI_RVALID(rvalid), .I_S_AXI_RREADY(rready), .O_CLK_OUT(clk_out),
        .O_CLK_TICK(tick), .O_STAGE1_CLK(s1_clk));
    ccd_consumer u_out (.i_clk(clk), .i_lvl(clk_out), .o_hi(out_hi), .o_lo(out_lo));
    ccd_consumer u_s1 (.i_clk(clk), .i_lvl(s1_clk), .o_hi(s1_hi), .o_lo(s1_lo));
    ccd_consumer u_tk (.i_clk(clk), .i_lvl(tick), .o_hi(tk_hi), .o_lo(tk_lo));
    // =============================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata  <= {24'h000000, d};
        wstrb  <= st;
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready)
                awv <= 1'b0;
            if (wready)
                wv <= 1'b0;
        end
        while (awv || wv);
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        check(bresp, er);
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arv    <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arv <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        check(rdata, exp);
        check(rresp, er);
    endtask
    // Let 200 cycles pass, then compare run lengths
    task automatic meas(input logic [31:0] e);
        repeat (200) @(posedge clk);
        check(out_hi, e[31:24]);
        check(out_lo, e[23:16]);
        check(s1_hi, e[15:8]);
        check(s1_lo, e[7:0]);
    endtask
    task automatic complete_run;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // =============================================
    // Test sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(ccd_pkg::IDX_PHASE, 32'h0, OK);
        rd(ccd_pkg::IDX_S2_CNT, 32'h0, OK);
        rd(ccd_pkg::IDX_CTRL, 32'h0, OK);
        rd(ccd_pkg::IDX_DCC, 32'h0, OK);
        rd(12'h100, 32'h0, ERR);
        wr(12'h100, 8'hFF, 4'hF, ERR);
        wr(ccd_pkg::IDX_PHASE, 8'hA5, 4'hF, OK);
        wr(ccd_pkg::IDX_PHASE, 8'h00, 4'h0, OK);
        rd(ccd_pkg::IDX_PHASE, 32'hA5, OK);
        wr(ccd_pkg::IDX_CTRL, 8'hFF, 4'hF, OK);
        rd(ccd_pkg::IDX_CTRL, 32'h3F, OK);
        wr(ccd_pkg::IDX_PHASE, 8'h00, 4'hF, OK);
        wr(ccd_pkg::IDX_DCC, 8'h01, 4'hF, OK);
        wr(ccd_pkg::IDX_S1_CNT, 8'h10, 4'hF, OK);
        rd(ccd_pkg::IDX_S1_CNT, 32'h10, OK);
        wr(ccd_pkg::IDX_S2_CNT, 8'h32, 4'hF, OK);
        // Plain, stage-two bypass, ignored force, stage-one bypass
        for (int i = 0; i < 4; i++)
        begin
            wr(ccd_pkg::IDX_CTRL, tbl[i][39:32], 4'hF, OK);
            meas(tbl[i][31:0]);
        end
        sync_n <= 1'b0;
        wr(ccd_pkg::IDX_CTRL, 8'h03, 4'hF, OK);
        repeat (20) @(posedge clk);
        check(clk_out, 32'h1);
        check(s1_clk, 32'h1);
        rd(ccd_pkg::IDX_STATUS, 32'hF, OK);
        wr(ccd_pkg::IDX_CTRL, 8'h00, 4'hF, OK);
        repeat (20) @(posedge clk);
        check(clk_out, 32'h0);
        check(s1_clk, 32'h0);
        wr(ccd_pkg::IDX_CTRL, 8'h0C, 4'hF, OK);
        repeat (200) @(posedge clk);
        check(clk_out, 32'h1);
        check(s1_hi, 32'h2);
        wr(ccd_pkg::IDX_CTRL, 8'h08, 4'hF, OK);
        repeat (20) @(posedge clk);
        check(clk_out, 32'h0);
        sync_n <= 1'b1;
        wr(ccd_pkg::IDX_CTRL, 8'h00, 4'hF, OK);
        wr(ccd_pkg::IDX_DCC, 8'h00, 4'hF, OK);
        repeat (200) @(posedge clk);
        check(out_hi, 32'd21);
        check(out_lo, 32'd21);
        check(tk_hi, 32'h1);
        check(tk_lo, 32'd41);
        complete_run;
    end
    // Hang guard at 20000 cycles, well beyond the roughly 1400 cycles the tests need
    initial
    begin
        #1000000;
        failures++;
        complete_run;
    end
endmodule
`default_nettype wire
